// ---- logic/hub_misc_pkg.sv ----
package hub_misc_pkg;

    // Reference clock rate and design clock rate
    localparam int unsigned REF_CLK_HZ       = 24_000_000;
    localparam int unsigned CORE_CLK_HZ      = 50_000_000;

    // Least external reset pulse, in nanoseconds
    localparam int unsigned EXT_RST_MIN_NS   = 1000;
    // Least pulse in core cycles, rounded up
    localparam int unsigned EXT_RST_MIN_CYC  =
        (EXT_RST_MIN_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;

    // Power-on reset hold after supplies report stable, in cycles
    localparam int unsigned POR_HOLD_CYC     = 16;

    // Counter width for the reset filters
    localparam int unsigned RST_CNT_W        = 8;

    // Reset values
    localparam logic [1:0]  FIXED_STRAP_RST  = 2'h0;
    localparam logic [2:0]  CFG_STRAP_RST    = 3'h0;

    // Configuration method codes that enable strap options
    localparam logic [2:0]  CFG_DEFAULT_STRAPS  = 3'h0;
    localparam logic [2:0]  CFG_BUSPWR_STRAPS   = 3'h2;

    // Fixed-port strap field positions
    localparam int unsigned STRAP_BIT0_POS   = 0;
    localparam int unsigned STRAP_BIT1_POS   = 1;

    // Reset sequencer states
    typedef enum logic [1:0] {
        RST_HOLD,
        RST_LATCH,
        RST_RUN
    } rst_state_t;

endpackage : hub_misc_pkg

// ---- logic/pin_sync.sv ----
`timescale 1ns/1ns
// Two-flop synchroniser for a group of asynchronous pin levels
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    // Synchroniser state
    typedef struct packed {
        logic [WIDTH-1:0] meta;   // First stage, read only by second
        logic [WIDTH-1:0] sync;   // Second stage
    } sync_state_t;

    sync_state_t state_ff;
    sync_state_t nxt_state;

    // Shift the pins through two stages
    always_comb begin
        nxt_state      = state_ff;
        nxt_state.meta = async_i;
        nxt_state.sync = state_ff.meta;
    end

    // Register the stages
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign sync_o = state_ff.sync;

endmodule : pin_sync

// ---- logic/hub_strap_reset_indicator.sv ----
`timescale 1ns/1ns
// Functional notes
// - Low external reset puts device in reset
// - Tied-high reset uses internal power-on reset
// - Indicator asserted only configured and active
// - Self-power sense low means bus powered
// - Sample strap only when strap options enabled
// - Latch two-bit fixed-port strap at release
// - Decode strap into fixed ports 1 to 3
// - Indicator polarity follows latched strap bit0
// - Test input enables XNOR continuity mode
// - Latch config-method straps at reset release
// - Strap options only for enabling config codes
module hub_strap_reset_indicator #(
    parameter int unsigned PORT_CNT = 7,
    parameter int unsigned TEST_W   = 8
) (
    // Core clock (derived from the reference) and core reset
    input  wire logic                core_clk_i,
    input  wire logic                rst_i,
    // External reset pin, active low, asynchronous
    input  wire logic                ext_reset_n_i,
    // Supplies-stable flag from the power monitor, asynchronous
    input  wire logic                supplies_ok_i,
    // Multifunction pin: indicator / self-power sense / strap bit0
    input  wire logic                mf_pin_i,
    output logic                     mf_pin_o,
    output logic                     mf_pin_oe_o,
    // Companion strap pin and configuration-method strap pins
    input  wire logic                fixed_port_strap_bit1_i,
    input  wire logic                config_method_strap_bit0_i,
    input  wire logic                config_method_strap_bit1_i,
    input  wire logic                config_method_strap_bit2_i,
    // Hub state from the protocol core
    input  wire logic                hub_configured_i,
    input  wire logic                hub_suspended_i,
    // Test mode pin and pins under continuity test
    input  wire logic                test_i,
    input  wire logic [TEST_W-1:0]   test_pins_i,
    // Status outputs
    output logic                     int_rst_o,
    output logic [1:0]               fixed_port_strap_o,
    output logic [PORT_CNT-1:0]      fixed_ports_o,
    output logic [2:0]               config_method_o,
    output logic                     strap_opts_en_o,
    output logic                     self_power_o,
    output logic                     test_mode_o,
    output logic                     continuity_o
);

    // Width of synchronised pin bundle: eight single pins plus the test pins
    localparam int unsigned SYNC_W = 8 + TEST_W;

    // Reset filter limits, sized to the filter counters
    localparam int unsigned      CNT_W   = hub_misc_pkg::RST_CNT_W;
    localparam logic [CNT_W-1:0] EXT_MIN = CNT_W'(hub_misc_pkg::EXT_RST_MIN_CYC); // Low pulse
    localparam logic [CNT_W-1:0] POR_MAX = CNT_W'(hub_misc_pkg::POR_HOLD_CYC);    // POR hold

    // Decode a fixed-port strap into a one-hot-run of fixed ports
    function automatic logic [PORT_CNT-1:0] fixed_decode(input logic [1:0] strap);
        logic [PORT_CNT-1:0] res;
        res = '0;
        case (strap)
            2'h0: res = '0;                          // All removable
            2'h1: res[0] = 1'b1;                     // Port 1 fixed
            2'h2: res[1:0] = 2'h3;                   // Ports 1-2 fixed
            2'h3: res[2:0] = 3'h7;                   // Ports 1-3 fixed
            default: res = '0;
        endcase
        return res;
    endfunction : fixed_decode

    // Decide whether a configuration method enables strap options
    function automatic logic strap_enable(input logic [2:0] cfg);
        return (cfg == hub_misc_pkg::CFG_DEFAULT_STRAPS) ||
               (cfg == hub_misc_pkg::CFG_BUSPWR_STRAPS);
    endfunction : strap_enable

    // Synchronised pins
    logic [SYNC_W-1:0] pins_sync;
    logic              s_ext_n;
    logic              s_sup_ok;
    logic              s_mf;
    logic              s_bit1;
    logic [2:0]        s_cfg;
    logic              s_conf;
    logic              s_susp;
    logic              s_test;
    logic [TEST_W-1:0] s_tpins;

    // All pins from outside the domain pass two flops
    pin_sync #(
        .WIDTH (SYNC_W)
    ) u_pin_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .async_i    ({test_pins_i, test_i, hub_suspended_i, hub_configured_i,
                      config_method_strap_bit2_i, config_method_strap_bit1_i,
                      config_method_strap_bit0_i, fixed_port_strap_bit1_i,
                      mf_pin_i}),
        .sync_o     (pins_sync)
    );

    // Unpack the bundle; ext reset and supplies sync below
    assign s_mf    = pins_sync[0];
    assign s_bit1  = pins_sync[1];
    assign s_cfg   = pins_sync[4:2];
    assign s_conf  = pins_sync[5];
    assign s_susp  = pins_sync[6];
    assign s_test  = pins_sync[7];
    assign s_tpins = pins_sync[SYNC_W-1:8];

    // Reset pins synchronised separately, power-up value asserted
    logic [1:0] rst_pins_sync;
    pin_sync #(
        .WIDTH (2)
    ) u_rst_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .async_i    ({supplies_ok_i, ext_reset_n_i}),
        .sync_o     (rst_pins_sync)
    );
    assign s_ext_n  = rst_pins_sync[0];
    assign s_sup_ok = rst_pins_sync[1];

    // Whole block state
    typedef struct packed {
        hub_misc_pkg::rst_state_t               st;        // Reset sequencer
        logic [hub_misc_pkg::RST_CNT_W-1:0]     low_cnt;   // External low time
        logic [hub_misc_pkg::RST_CNT_W-1:0]     por_cnt;   // Power-on hold time
        logic                                   int_rst;   // Internal reset
        logic [1:0]                             fixed;     // Latched fixed strap
        logic [PORT_CNT-1:0]                    fixed_pt;  // Decoded fixed ports
        logic [2:0]                             cfg;       // Latched method
        logic                                   sopt;      // Strap options on
        logic                                   self_pwr;  // Self-power level
        logic                                   pin_o;     // Pin drive level
        logic                                   pin_oe;    // Pin drive enable
        logic                                   tmode;     // Test mode
        logic                                   cont;      // Continuity result
    } blk_state_t;

    blk_state_t state_ff;
    blk_state_t nxt_state;

    // Next-state logic
    always_comb begin
        logic ext_ok;
        logic ind_on;
        ext_ok    = 1'b0;
        ind_on    = 1'b0;
        nxt_state = state_ff;
        // Accept external reset only after a full least-length low pulse
        if (!s_ext_n) begin
            if (state_ff.low_cnt < EXT_MIN) begin
                nxt_state.low_cnt = state_ff.low_cnt + 1'b1;
            end
        end else begin
            nxt_state.low_cnt = '0;
        end
        ext_ok = s_ext_n;
        // Power-on hold: count while supplies good, clear otherwise
        if (!s_sup_ok) begin
            nxt_state.por_cnt = '0;
        end else if (state_ff.por_cnt < POR_MAX) begin
            nxt_state.por_cnt = state_ff.por_cnt + 1'b1;
        end
        case (state_ff.st)
            hub_misc_pkg::RST_HOLD: begin
                // Internal logic held; pin is an input
                nxt_state.int_rst = 1'b1;
                nxt_state.pin_oe  = 1'b0;
                if (ext_ok && s_sup_ok &&
                    state_ff.por_cnt == POR_MAX) begin
                    nxt_state.st = hub_misc_pkg::RST_LATCH;
                end
            end
            hub_misc_pkg::RST_LATCH: begin
                // Reset release: capture straps while the pin is undriven
                nxt_state.cfg  = s_cfg;
                nxt_state.sopt = strap_enable(s_cfg);
                if (strap_enable(s_cfg)) begin
                    nxt_state.fixed[hub_misc_pkg::STRAP_BIT0_POS] = s_mf;
                    nxt_state.fixed[hub_misc_pkg::STRAP_BIT1_POS] = s_bit1;
                    nxt_state.fixed_pt = fixed_decode({s_bit1, s_mf});
                end else begin
                    nxt_state.fixed    = hub_misc_pkg::FIXED_STRAP_RST;
                    nxt_state.fixed_pt = '0;
                end
                nxt_state.self_pwr = s_mf;
                nxt_state.int_rst  = 1'b0;
                nxt_state.st       = hub_misc_pkg::RST_RUN;
            end
            hub_misc_pkg::RST_RUN: begin
                // Indicator on only when configured and not suspended
                ind_on           = s_conf && !s_susp;
                nxt_state.pin_o  = ind_on ^ state_ff.fixed[0];
                nxt_state.pin_oe = 1'b1;
                nxt_state.tmode  = s_test;
                nxt_state.cont   = s_test ? ~(^s_tpins) : 1'b0;
            end
            default: begin
                nxt_state.st = hub_misc_pkg::RST_HOLD;
            end
        endcase
        // A qualified low pulse or lost supplies returns the sequencer to hold, asserts internal reset and clears pin drive and test outputs
        if (state_ff.low_cnt == EXT_MIN
            || !s_sup_ok) begin
            nxt_state.st      = hub_misc_pkg::RST_HOLD;
            nxt_state.int_rst = 1'b1;
            nxt_state.pin_oe  = 1'b0;
            nxt_state.pin_o   = 1'b0;
            nxt_state.tmode   = 1'b0;
            nxt_state.cont    = 1'b0;
        end
    end

    // Register the state
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_ff          <= '0;
            state_ff.st       <= hub_misc_pkg::RST_HOLD;
            state_ff.int_rst  <= 1'b1;
            state_ff.fixed    <= hub_misc_pkg::FIXED_STRAP_RST;
            state_ff.cfg      <= hub_misc_pkg::CFG_STRAP_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs straight from flops
    assign int_rst_o          = state_ff.int_rst;
    assign fixed_port_strap_o = state_ff.fixed;
    assign fixed_ports_o      = state_ff.fixed_pt;
    assign config_method_o    = state_ff.cfg;
    assign strap_opts_en_o    = state_ff.sopt;
    assign self_power_o       = state_ff.self_pwr;
    assign mf_pin_o           = state_ff.pin_o;
    assign mf_pin_oe_o        = state_ff.pin_oe;
    assign test_mode_o        = state_ff.tmode;
    assign continuity_o       = state_ff.cont;

endmodule : hub_strap_reset_indicator

// ---- sim/board_model.sv ----
`timescale 1ns/1ns
// Board side of the multifunction pin: strap resistor plus indicator LED
module board_model (
    // Device side of the pin
    input  wire logic mf_pin_o,
    input  wire logic mf_pin_oe_o,
    // Strap resistor level
    input  wire logic strap_level_i,
    // Level seen back at the pin
    output logic      mf_pin_i
);
    // The device drive wins over the weak strap resistor
    assign mf_pin_i = mf_pin_oe_o ? mf_pin_o : strap_level_i;
endmodule : board_model

// ---- sim/hub_strap_reset_indicator_checker.sv ----
`timescale 1ns/1ns
// Watches the strap, reset and indicator outputs
module hub_strap_reset_indicator_checker #(
    parameter int unsigned PORT_CNT = 7
) (
    input wire logic                core_clk_i,
    input wire logic                rst_i,
    input wire logic                supplies_ok_i,
    input wire logic                hub_configured_i,
    input wire logic                hub_suspended_i,
    input wire logic                int_rst_o,
    input wire logic                mf_pin_o,
    input wire logic                mf_pin_oe_o,
    input wire logic [1:0]          fixed_port_strap_o,
    input wire logic [PORT_CNT-1:0] fixed_ports_o,
    input wire logic [2:0]          config_method_o,
    input wire logic                strap_opts_en_o,
    input wire logic                self_power_o,
    input wire logic                test_mode_o,
    input wire logic                continuity_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic       act;      // Hub configured and not suspended
    logic       act_q;    // Previous hub activity
    logic [2:0] stab_cnt; // Cycles the activity has stood still
    assign act = hub_configured_i && !hub_suspended_i;
    // Count how long the activity level has been steady
    always_ff @(posedge core_clk_i) begin
        act_q <= act;
        if (rst_i || act != act_q) stab_cnt <= 3'h0;
        else if (stab_cnt != 3'h7) stab_cnt <= stab_cnt + 3'h1;
    end
    opts_code_a: assert property (!int_rst_o |->
        strap_opts_en_o == (config_method_o == 3'h0 || config_method_o == 3'h2))
        else $error("strap enable does not match config code");
    strap_ignored_a: assert property (!int_rst_o && !strap_opts_en_o |->
        fixed_port_strap_o == 2'h0) else $error("strap taken while disabled");
    port_decode_a: assert property (!int_rst_o |-> fixed_ports_o ==
        PORT_CNT'({&fixed_port_strap_o, fixed_port_strap_o[1], |fixed_port_strap_o}))
        else $error("fixed ports decode wrong");
    ind_polarity_a: assert property (mf_pin_oe_o && act == act_q &&
        stab_cnt >= 3'h5 |-> mf_pin_o == (act ^ fixed_port_strap_o[0]))
        else $error("indicator level wrong");
    oe_after_latch_a: assert property ($rose(mf_pin_oe_o) |->
        !$past(int_rst_o) && $past(int_rst_o, 2)) else $error("pin driven too early");
    oe_off_hold_a: assert property (int_rst_o && $past(int_rst_o) |->
        !mf_pin_oe_o) else $error("pin driven in reset");
    strap_hold_a: assert property (!int_rst_o && !$past(int_rst_o) |->
        $stable(fixed_port_strap_o) && $stable(config_method_o) && $stable(self_power_o))
        else $error("latched strap changed");
    supply_hold_a: assert property (!supplies_ok_i |-> ##[1:4] int_rst_o)
        else $error("no reset on supply loss");
    cont_off_a: assert property (!test_mode_o && !$past(test_mode_o) |->
        !continuity_o) else $error("continuity outside test mode");
    cover property ($fell(int_rst_o));
    cover property (!int_rst_o && fixed_port_strap_o == 2'h3);
    cover property (test_mode_o && continuity_o);
endmodule : hub_strap_reset_indicator_checker
bind hub_strap_reset_indicator hub_strap_reset_indicator_checker #(.PORT_CNT(PORT_CNT)) chk (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .supplies_ok_i(supplies_ok_i),
    .hub_configured_i(hub_configured_i), .hub_suspended_i(hub_suspended_i),
    .int_rst_o(int_rst_o), .mf_pin_o(mf_pin_o), .mf_pin_oe_o(mf_pin_oe_o),
    .fixed_port_strap_o(fixed_port_strap_o), .fixed_ports_o(fixed_ports_o),
    .config_method_o(config_method_o), .strap_opts_en_o(strap_opts_en_o),
    .self_power_o(self_power_o), .test_mode_o(test_mode_o), .continuity_o(continuity_o));

// ---- sim/hub_strap_reset_indicator_tb.sv ----
`timescale 1ns/1ns
module hub_strap_reset_indicator_tb;
    logic       core_clk_i = 1'b0; // 50 MHz core clock
    logic       rst_i = 1'b1;
    logic       ext_n = 1'b1, sup_ok = 1'b1, strap0 = 1'b0, bit1 = 1'b0;
    logic       conf = 1'b0, susp = 1'b0, test = 1'b0, en;
    logic [2:0] cfg = 3'h0;
    logic [7:0] pins = 8'h00;
    logic       mf_i, mf_o, mf_oe, irst, opts, spow, tmode, cont;
    logic [1:0] fstrap, s, fs;
    logic [6:0] fports;
    logic [2:0] cmeth;
    int         num_errors = 0, n_compared = 0, cyc = 0;
    always #10 core_clk_i = ~core_clk_i;
    board_model bm (.mf_pin_o(mf_o), .mf_pin_oe_o(mf_oe), .strap_level_i(strap0),
        .mf_pin_i(mf_i));
    hub_strap_reset_indicator uut (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .ext_reset_n_i(ext_n), .supplies_ok_i(sup_ok), .mf_pin_i(mf_i), .mf_pin_o(mf_o),
        .mf_pin_oe_o(mf_oe), .fixed_port_strap_bit1_i(bit1),
        .config_method_strap_bit0_i(cfg[0]), .config_method_strap_bit1_i(cfg[1]),
        .config_method_strap_bit2_i(cfg[2]), .hub_configured_i(conf),
        .hub_suspended_i(susp), .test_i(test), .test_pins_i(pins), .int_rst_o(irst),
        .fixed_port_strap_o(fstrap), .fixed_ports_o(fports), .config_method_o(cmeth),
        .strap_opts_en_o(opts), .self_power_o(spow), .test_mode_o(tmode),
        .continuity_o(cont));
    // Compare one result and count it
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : tick
    // Bounded wait for the internal reset to drop
    task automatic wait_run;
        int k;
        k = 0;
        while (irst !== 1'b0 && k < 300) begin
            tick(1);
            k++;
        end
        check({7'h00, irst}, 8'h00, "release");
    endtask : wait_run
    task automatic final_report;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    // Hang guard
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            final_report();
        end
    end
    initial begin
        tick(12);
        check({7'h00, irst}, 8'h01, "held");
        rst_i = 1'b0;
        wait_run();
        // Every config code, strap values cycling through all four
        for (int i = 0; i < 8; i++) begin
            s = i[1:0];
            strap0 = s[0];
            bit1 = s[1];
            cfg = i[2:0];
            ext_n = 1'b0;
            tick(60);
            check({7'h00, irst}, 8'h01, "ext hold");
            ext_n = 1'b1;
            wait_run();
            en = (i == 0) || (i == 2);
            fs = en ? s : 2'h0;
            check({5'h00, cmeth}, i[7:0], "cfg");
            check({7'h00, opts}, {7'h00, en}, "opts");
            check({6'h00, fstrap}, {6'h00, fs}, "strap");
            check({1'h0, fports}, {5'h00, &fs, fs[1], |fs}, "ports");
            check({7'h00, spow}, {7'h00, s[0]}, "power");
            tick(6);
            check({7'h00, mf_oe}, 8'h01, "drive");
            check({7'h00, mf_o}, {7'h00, fs[0]}, "unconf");
            conf = 1'b1;
            tick(6);
            check({7'h00, mf_o}, {7'h00, ~fs[0]}, "active");
            susp = 1'b1;
            tick(6);
            check({7'h00, mf_o}, {7'h00, fs[0]}, "suspend");
            conf = 1'b0;
            susp = 1'b0;
        end
        // A short low on the external reset is ignored
        ext_n = 1'b0;
        tick(30);
        check({7'h00, irst}, 8'h00, "short held");
        ext_n = 1'b1;
        tick(40);
        check({7'h00, irst}, 8'h00, "short low");
        // Supply loss holds the logic in reset
        sup_ok = 1'b0;
        tick(5);
        check({7'h00, irst}, 8'h01, "supply");
        sup_ok = 1'b1;
        wait_run();
        // Continuity over two parities
        test = 1'b1;
        pins = 8'h5a;
        tick(6);
        check({7'h00, tmode}, 8'h01, "test");
        check({7'h00, cont}, {7'h00, ~^pins}, "even");
        pins = 8'h5b;
        tick(6);
        check({7'h00, cont}, {7'h00, ~^pins}, "odd");
        test = 1'b0;
        tick(6);
        check({7'h00, tmode}, 8'h00, "test off");
        check({7'h00, cont}, 8'h00, "cont off");
        final_report();
    end
endmodule : hub_strap_reset_indicator_tb
